// *** common/rtc_consts.svh ***
// Offsets, bit positions, reset values and timing counts of the clock core
// How it works
// - Time advances once per second in update
// - Frozen user copy; internal copy keeps counting
// - Pending bit leads update unless frozen; done flag ends
// - Format bits pick BCD/binary and 12/24h
// - Crystal divider chain makes one second
// - Thirteen taps into one sixteen-way selector
// - Rate code picks tap; zero means none
// - Square wave toggles only when enabled
// - Code 011 with fast enable: raw crystal
// - Raw crystal leaves periodic rate unchanged
// - Events always flag; request needs enable
// - Request flag set with every request
// - Flag read clears flags, releases request
// - Periodic request at selected rate
// - Alarm compare each update, sets match
// - Top bits both one: byte ignored
// - Alarm works independent of host bus
// - Update request needs enable and unfrozen
// - Hour byte bit 7 marks PM in 12-hour mode
// - Fourteen control bytes, then storage bytes
// - Square wave low when disabled
// - Request pin low while enabled flag set
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// Register offsets
`define RTC_OFS_SEC 7'h00
`define RTC_OFS_HOUR 7'h04
`define RTC_OFS_YEAR 7'h09
`define RTC_OFS_A 7'h0A
`define RTC_OFS_B 7'h0B
`define RTC_OFS_C 7'h0C
`define RTC_OFS_D 7'h0D
`define RTC_OFS_RAM 7'h0E
// Control bits
`define RTC_B_FREEZE 7
`define RTC_B_PER_IE 6
`define RTC_B_ALM_IE 5
`define RTC_B_UPD_IE 4
`define RTC_B_WAVE_EN 3
`define RTC_B_BIN 2
`define RTC_B_H24 1
`define RTC_C_K32 0
`define RTC_OS_RUN 2'h1
`define RTC_OS_FAST 3'h3
`define RTC_DONT_CARE 2'h3
`define RTC_D_VALUE 8'h80
// Reset values
`define RTC_RST_A 7'h26
`define RTC_RST_ONE 8'h01
// Divider and lead time in crystal ticks
`define RTC_XTAL_HZ 32768
`define RTC_LEAD_US 244
`define RTC_LEAD_TICKS ((`RTC_LEAD_US * `RTC_XTAL_HZ + 999999) / 1000000)
`define RTC_DIV_MAX 15'h7FFF
`define RTC_DIV_HALF 15'h4000
`define RTC_PEND_START (`RTC_DIV_MAX - 15'(`RTC_LEAD_TICKS) + 15'h0001)
`endif

// *** common/rtc_pkg.sv ***
// Types shared by the clock core
package rtc_pkg;
  // Sampled host bus pins
  typedef struct packed {
    logic cs_n; // Chip select, low active
    logic as; // Address strobe, falling edge latches
    logic rd_n; // Read strobe, low active
    logic wr_n; // Write strobe, rising edge latches
    logic [7:0] ad; // Address/data lines
  } rtc_bus_s;
  // Whole state of the core
  typedef struct packed {
    logic [9:0][7:0] user; // Host-visible time and alarm bytes
    logic [9:0][7:0] intern; // Internal counting copy
    logic [113:0][7:0] ram; // General storage
    logic [6:0] reg_a; // Divider control and rate code
    logic [7:0] reg_b; // Enables and formats
    logic pf; // Periodic flag
    logic alarm_match_flag; // Alarm match flag
    logic update_done_flag; // Update done flag
    logic irqf; // Request flag
    logic k32; // Fast clock out enable
    logic update_pending; // Update pending
    logic [14:0] div; // Crystal divider
    logic tap_q; // Last selector output
    logic osc_q; // Last crystal level
    logic [6:0] addr; // Latched address
    rtc_bus_s bus_q; // Last bus sample
    logic [7:0] ad_out; // Read data
    logic ad_oe_n; // Data drive enable, low drives
    logic int_out; // Request pin level when driven
    logic int_oe_n; // Request drive enable, low drives
    logic square_wave_out; // Square wave output
  } rtc_state_s;
endpackage

// *** design/rtc_core.sv ***
// Clock, calendar, alarm, divider and flag logic behind the host bus
`timescale 1ns/100ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_core (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_reset, // Async reset, high
  input wire rtc_pkg::rtc_bus_s i_bus, // Host bus pins
  input wire logic i_osc, // Crystal level
  output var logic [7:0] o_ad, // Data out
  output var logic o_ad_oe_n, // Data drive enable, low drives
  output var logic o_int, // Request level, always low
  output var logic o_int_oe_n, // Request drive, low asserts
  output var logic o_square_wave_out // Square wave
);

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers

  // Byte to binary value
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
  endfunction

  // Binary value to byte
  function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
    return bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
  endfunction

  // Days in a month, two-digit leap years
  function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yr);
    case (mo)
      8'h02: return (yr[1:0] == 2'h0) ? 8'd29 : 8'd28;
      8'h04, 8'h06, 8'h09, 8'h0B: return 8'd30;
      default: return 8'd31;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  rtc_pkg::rtc_state_s s; // Current state
  rtc_pkg::rtc_state_s next_s; // Next state
  logic [15:0] mux_in; // Selector inputs
  logic mux_out; // Selected tap
  logic tick; // Crystal rising edge
  logic run; // Divider enabled
  logic upd; // Update cycle this cycle
  logic fmt_bin; // Binary format
  logic fmt_24; // 24-hour format
  logic [7:0] sec; // Binary seconds
  logic [7:0] mins; // Binary minutes
  logic [7:0] hb; // Raw binary hour
  logic [7:0] hr; // Hour 0..23
  logic [7:0] hm; // Hour modulo 12
  logic [7:0] h12; // Hour 1..12
  logic [7:0] hbyte; // Encoded hour
  logic [7:0] wd; // Weekday
  logic [7:0] dt; // Date
  logic [7:0] mo; // Month
  logic [7:0] yr; // Year
  logic [2:0] hit; // Alarm byte matches
  logic rd_end; // End of read strobe
  logic wr_end; // End of write strobe
  logic [7:0] rdata; // Read mux
  logic [6:0] ram_ix; // Storage index
  logic irq; // Request condition

  ////////////////////////////////////////////////////////////////////////////
  // Divider tap selector

  // Sixteen inputs from thirteen taps; code 0 is silent
  genvar g;
  for (g = 0; g < 16; g++) begin : g_tap
    if (g == 0) begin : g_none
      assign mux_in[g] = 1'b0;
    end else if (g < 3) begin : g_low
      assign mux_in[g] = s.div[g + 5];
    end else begin : g_high
      assign mux_in[g] = s.div[g - 2];
    end
  end
  assign mux_out = mux_in[s.reg_a[3:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // All behaviour in one pass
  always_comb begin
    next_s = s;
    fmt_bin = s.reg_b[`RTC_B_BIN];
    fmt_24 = s.reg_b[`RTC_B_H24];
    tick = i_osc & ~s.osc_q;
    next_s.osc_q = i_osc;
    run = (s.reg_a[6:5] == `RTC_OS_RUN); // Patterns 010 and 011
    upd = run & tick & (s.div == `RTC_DIV_MAX);
    sec = 8'h00;
    mins = 8'h00;
    hb = 8'h00;
    hr = 8'h00;
    hm = 8'h00;
    h12 = 8'h00;
    hbyte = 8'h00;
    wd = 8'h00;
    dt = 8'h00;
    mo = 8'h00;
    yr = 8'h00;
    hit = 3'h0;
    // Divider: held half way when off so first update is 500 ms later
    if (!run) begin
      next_s.div = `RTC_DIV_HALF;
    end else if (tick) begin
      next_s.div = s.div + 15'h0001;
    end
    // Update cycle on divider wrap
    if (upd) begin
      sec = to_bin(s.intern[0], fmt_bin);
      mins = to_bin(s.intern[2], fmt_bin);
      hb = to_bin({1'b0, s.intern[4][6:0]}, fmt_bin);
      // Hour into 0..23, bit 7 is PM in 12-hour mode
      if (fmt_24) begin
        hr = hb;
      end else begin
        hr = ((hb == 8'd12) ? 8'd0 : hb) + (s.intern[4][7] ? 8'd12 : 8'd0);
      end
      wd = to_bin(s.intern[6], fmt_bin);
      dt = to_bin(s.intern[7], fmt_bin);
      mo = to_bin(s.intern[8], fmt_bin);
      yr = to_bin(s.intern[9], fmt_bin);
      sec = sec + 8'd1;
      // Carry chain through the calendar
      if (sec >= 8'd60) begin
        sec = 8'd0;
        mins = mins + 8'd1;
        if (mins >= 8'd60) begin
          mins = 8'd0;
          hr = hr + 8'd1;
          if (hr >= 8'd24) begin
            hr = 8'd0;
            wd = (wd >= 8'd7) ? 8'd1 : wd + 8'd1;
            dt = dt + 8'd1;
            if (dt > month_days(mo, yr)) begin
              dt = 8'd1;
              mo = mo + 8'd1;
              if (mo > 8'd12) begin
                mo = 8'd1;
                yr = (yr >= 8'd99) ? 8'd0 : yr + 8'd1;
              end
            end
          end
        end
      end
      // Hour back to the chosen coding
      hm = (hr >= 8'd12) ? hr - 8'd12 : hr;
      h12 = (hm == 8'd0) ? 8'd12 : hm;
      if (fmt_24) begin
        hbyte = from_bin(hr, fmt_bin);
      end else begin
        hbyte = from_bin(h12, fmt_bin);
        hbyte[7] = (hr >= 8'd12);
      end
      next_s.intern[0] = from_bin(sec, fmt_bin);
      next_s.intern[2] = from_bin(mins, fmt_bin);
      next_s.intern[4] = hbyte;
      next_s.intern[6] = from_bin(wd, fmt_bin);
      next_s.intern[7] = from_bin(dt, fmt_bin);
      next_s.intern[8] = from_bin(mo, fmt_bin);
      next_s.intern[9] = from_bin(yr, fmt_bin);
      // Alarm compare; needs no bus activity so it runs on backup too
      for (int i = 0; i < 3; i++) begin
        hit[i] = (s.user[2 * i + 1][7:6] == `RTC_DONT_CARE)
          | (s.user[2 * i + 1] == next_s.intern[2 * i]);
      end
    end
    // Host copy follows the internal one unless frozen
    if (!s.reg_b[`RTC_B_FREEZE]) begin
      for (int i = 0; i < 10; i++) begin
        if (i != 1 && i != 3 && i != 5) begin
          next_s.user[i] = next_s.intern[i];
        end
      end
    end
    // Bus: address latch on strobe fall
    if (s.bus_q.as & ~i_bus.as) begin
      next_s.addr = i_bus.ad[6:0];
    end
    next_s.bus_q = i_bus;
    rd_end = ~s.bus_q.cs_n & ~s.bus_q.rd_n & i_bus.rd_n;
    wr_end = ~s.bus_q.cs_n & ~s.bus_q.wr_n & i_bus.wr_n;
    ram_ix = 7'(s.addr - `RTC_OFS_RAM);
    // Read data by address
    if (s.addr <= `RTC_OFS_YEAR) begin
      rdata = s.user[4'(s.addr)];
    end else if (s.addr == `RTC_OFS_A) begin
      rdata = {s.update_pending, s.reg_a};
    end else if (s.addr == `RTC_OFS_B) begin
      rdata = s.reg_b;
    end else if (s.addr == `RTC_OFS_C) begin
      rdata = {s.irqf, s.pf, s.alarm_match_flag, s.update_done_flag, 3'h0, s.k32};
    end else if (s.addr == `RTC_OFS_D) begin
      rdata = `RTC_D_VALUE;
    end else begin
      rdata = s.ram[ram_ix];
    end
    // Drive data while selected and read strobe low
    next_s.ad_oe_n = ~(~i_bus.cs_n & ~i_bus.rd_n);
    next_s.ad_out = rdata;
    // Write on rising edge of write strobe
    if (wr_end) begin
      if (s.addr <= `RTC_OFS_YEAR) begin
        next_s.user[4'(s.addr)] = s.bus_q.ad;
        next_s.intern[4'(s.addr)] = s.bus_q.ad;
      end else if (s.addr == `RTC_OFS_A) begin
        next_s.reg_a = s.bus_q.ad[6:0];
      end else if (s.addr == `RTC_OFS_B) begin
        next_s.reg_b = s.bus_q.ad;
      end else if (s.addr == `RTC_OFS_C) begin
        // Writable only under pattern 011
        if (s.reg_a[6:4] == `RTC_OS_FAST) begin
          next_s.k32 = s.bus_q.ad[`RTC_C_K32];
        end
      end else if (s.addr >= `RTC_OFS_RAM) begin
        next_s.ram[ram_ix] = s.bus_q.ad;
      end
    end
    // Flag register read clears all flags first
    if (rd_end && s.addr == `RTC_OFS_C) begin
      next_s.pf = 1'b0;
      next_s.alarm_match_flag = 1'b0;
      next_s.update_done_flag = 1'b0;
      next_s.irqf = 1'b0;
    end
    // Events set afterwards so they win over the clear
    next_s.tap_q = mux_out;
    if (s.tap_q & ~mux_out) begin
      next_s.pf = 1'b1;
    end
    if (upd && (&hit)) begin
      next_s.alarm_match_flag = 1'b1;
    end
    if (upd) begin
      next_s.update_done_flag = 1'b1;
    end
    // Pending bit before the wrap, off while frozen
    next_s.update_pending = run & ~next_s.reg_b[`RTC_B_FREEZE]
      & (next_s.div >= `RTC_PEND_START);
    // Request from enabled flags
    irq = (next_s.pf & next_s.reg_b[`RTC_B_PER_IE])
      | (next_s.alarm_match_flag & next_s.reg_b[`RTC_B_ALM_IE])
      | (next_s.update_done_flag & next_s.reg_b[`RTC_B_UPD_IE]
      & ~next_s.reg_b[`RTC_B_FREEZE]);
    next_s.irqf = next_s.irqf | irq;
    next_s.int_oe_n = ~irq;
    next_s.int_out = 1'b0;
    // Square wave: raw crystal, selected tap, or held low
    if (!s.reg_b[`RTC_B_WAVE_EN]) begin
      next_s.square_wave_out = 1'b0;
    end else if (s.reg_a[6:4] == `RTC_OS_FAST && s.k32) begin
      next_s.square_wave_out = i_osc;
    end else begin
      next_s.square_wave_out = mux_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // State flops with constant reset values
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
      s.user[6] <= `RTC_RST_ONE;
      s.user[7] <= `RTC_RST_ONE;
      s.user[8] <= `RTC_RST_ONE;
      s.intern[6] <= `RTC_RST_ONE;
      s.intern[7] <= `RTC_RST_ONE;
      s.intern[8] <= `RTC_RST_ONE;
      s.reg_a <= `RTC_RST_A;
      s.div <= `RTC_DIV_HALF;
      s.bus_q <= '1;
      s.ad_oe_n <= 1'b1;
      s.int_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign o_ad = s.ad_out;
  assign o_ad_oe_n = s.ad_oe_n;
  assign o_int = s.int_out;
  assign o_int_oe_n = s.int_oe_n;
  assign o_square_wave_out = s.square_wave_out;

endmodule // rtc_core
`default_nettype wire

// *** test/rtc_core_sva.sv ***
// Port checker for the clock core, bound to its top
`timescale 1ns/100ps
`default_nettype none
module rtc_core_sva (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Async reset
  input wire rtc_pkg::rtc_bus_s i_bus, // Host bus
  input wire logic i_osc, // Crystal
  input wire logic o_ad_oe_n, // Data drive, low drives
  input wire logic o_int, // Request level
  input wire logic o_int_oe_n, // Request drive
  input wire logic o_square_wave_out // Square wave
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  logic rd_now; // Read strobe held
  logic str_q; // Last strobe level
  logic osc_q; // Last crystal level
  logic [2:0] str_age; // Cycles since a strobe ended
  logic [2:0] osc_age; // Cycles since a crystal rise
  assign rd_now = !i_bus.cs_n && !i_bus.rd_n;
  //////////////////////////////////////////
  // Saturating ages tie outputs to their causes
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      str_q <= 1'b1;
      osc_q <= 1'b0;
      str_age <= 3'h7;
      osc_age <= 3'h7;
    end else begin
      str_q <= i_bus.rd_n && i_bus.wr_n;
      osc_q <= i_osc;
      str_age <= (!str_q && i_bus.rd_n && i_bus.wr_n) ? 3'h0 : str_age + {2'h0, str_age != 3'h7};
      osc_age <= (!osc_q && i_osc) ? 3'h0 : osc_age + {2'h0, osc_age != 3'h7};
    end
  end
  //////////////////////////////////////////
  property p_int_level; o_int == 1'b0; endproperty
  a_int_level: assert property (p_int_level) else $error("request level not low");
  property p_rd_drive; rd_now |=> !o_ad_oe_n; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read not answered");
  property p_rd_only; !o_ad_oe_n |-> $past(rd_now); endproperty
  a_rd_only: assert property (p_rd_only) else $error("data driven outside read");
  property p_rd_release; $rose(i_bus.rd_n) |=> o_ad_oe_n; endproperty
  a_rd_release: assert property (p_rd_release) else $error("data held after read");
  property p_wr_quiet; (!i_bus.cs_n && i_bus.rd_n) [*2] |-> o_ad_oe_n; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("data driven in write");
  property p_int_release; $rose(o_int_oe_n) |-> str_age <= 3'h3; endproperty
  a_int_release: assert property (p_int_release) else $error("request dropped unread");
  property p_int_raise; $fell(o_int_oe_n) |-> osc_age <= 3'h4 || str_age <= 3'h4; endproperty
  a_int_raise: assert property (p_int_raise) else $error("request without event");
  property p_wave_cause;
    $changed(o_square_wave_out) |-> osc_age <= 3'h3 || str_age <= 3'h4;
  endproperty
  a_wave_cause: assert property (p_wave_cause) else $error("wave moved without tick");
  // Main scenarios reached
  c_int_release: cover property ($rose(o_int_oe_n));
  c_int_raise: cover property ($fell(o_int_oe_n));
  c_wave_move: cover property ($changed(o_square_wave_out));
endmodule // rtc_core_sva
bind rtc_core rtc_core_sva rtc_core_sva_inst (.i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus),
  .i_osc(i_osc), .o_ad_oe_n(o_ad_oe_n), .o_int(o_int), .o_int_oe_n(o_int_oe_n),
  .o_square_wave_out(o_square_wave_out));
`default_nettype wire

// *** test/rtc_host_model.sv ***
// Host processor model on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
  input wire logic i_clk, // Clock
  input wire logic [7:0] i_ad, // Device read data
  input wire logic i_ad_oe_n, // Device drives when low
  output var rtc_pkg::rtc_bus_s o_bus // Bus pins
);
  // Idle bus from time zero
  initial o_bus = '{cs_n: 1'b1, as: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};
  // Address phase, latched on the strobe fall
  task automatic latch(input logic [6:0] a);
    @(posedge i_clk);
    o_bus.as <= 1'b1;
    o_bus.ad <= {1'b0, a};
    @(posedge i_clk);
    o_bus.as <= 1'b0;
  endtask
  // Write, data taken on the strobe rise
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    latch(a);
    @(posedge i_clk);
    o_bus.cs_n <= 1'b0;
    o_bus.wr_n <= 1'b0;
    o_bus.ad <= d;
    @(posedge i_clk);
    o_bus.wr_n <= 1'b1;
    @(posedge i_clk);
    o_bus.cs_n <= 1'b1;
    o_bus.ad <= ~d; // Released lines do not keep the last value
  endtask
  // Read, held until the device drives
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    latch(a);
    @(posedge i_clk);
    o_bus.cs_n <= 1'b0;
    o_bus.rd_n <= 1'b0;
    o_bus.ad <= ~o_bus.ad;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ad_oe_n !== 1'b0 && n < 8);
    d = (i_ad_oe_n === 1'b0) ? i_ad : 8'hXX;
    o_bus.rd_n <= 1'b1;
    o_bus.cs_n <= 1'b1;
  endtask
endmodule // rtc_host_model
`default_nettype wire

// *** test/rtc_update_alarm_interrupts_tb_top.sv ***
// Self-checking bench for the clock core
`timescale 1ns/100ps
`default_nettype none
module rtc_update_alarm_interrupts_tb_top;
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset
  logic osc = 1'b0; // Crystal, a tick every two clocks
  rtc_pkg::rtc_bus_s bus; // Host bus
  logic [7:0] ad; // Read data
  logic ad_oe_n; // Data drive
  logic irq; // Request level
  logic irq_oe_n; // Request drive
  logic wave; // Square wave
  logic [15:0] lfsr = 16'h95A9; // Fixed seed
  int err_total = 0; // Mismatches
  int checks_done = 0; // Comparisons
  int cyc = 0; // Cycles run
  logic [7:0] tset [10] = '{8'h3B, 8'h00, 8'h3B, 8'h00, 8'h17, 8'hC0, 8'h07, 8'h1F, 8'h0C, 8'h63};
  logic [7:0] troll [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
  always #5 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  rtc_core rtc_core_inst (.i_clk(clk), .i_reset(rst), .i_bus(bus), .i_osc(osc), .o_ad(ad),
    .o_ad_oe_n(ad_oe_n), .o_int(irq), .o_int_oe_n(irq_oe_n), .o_square_wave_out(wave));
  rtc_host_model rtc_host_model_inst (.i_clk(clk), .i_ad(ad), .i_ad_oe_n(ad_oe_n), .o_bus(bus));
  //////////////////////////////////////////
  // Expectations and helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_rst(input logic [6:0] a);
    case (a)
      7'h06, 7'h07, 7'h08: return 8'h01;
      7'h0A: return 8'h26;
      7'h0D: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  // Wave rises in a window; ticks per period from the rate code
  function automatic int exp_rises(input int c, input int w);
    int t;
    if (c == 0) return 0;
    t = (c < 3) ? (1 << (c + 6)) : (1 << (c - 1));
    return w / (2 * t);
  endfunction
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    rtc_host_model_inst.wr(a, d);
  endtask
  task automatic rd8(input logic [6:0] a, output logic [7:0] d);
    rtc_host_model_inst.rd(a, d);
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int exp, input int got, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("ERROR %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task automatic count_wave(input int cycles, output int r);
    logic last;
    last = wave;
    r = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (wave === 1'b1 && last === 1'b0) r++;
      last = wave;
    end
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_oe_n !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk8("request raised", 8'h00, {7'h00, irq_oe_n});
  endtask
  task automatic poll(input logic [6:0] a, input int b, output logic [7:0] d);
    int n;
    n = 0;
    do begin
      rd8(a, d);
      n++;
    end while (d[b] !== 1'b1 && n < 8000);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      $display("ERROR timeout exp finish got hang");
      wrap_up();
    end
  end
  //////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [6:0] a;
    int r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Map reset values, random storage, fixed byte
    for (int i = 0; i < 14; i++) begin
      rd8(7'(i), d);
      chk8("reset byte", exp_rst(7'(i)), d);
    end
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      a = 7'(14 + lfsr[6:0] % 114);
      wr8(a, lfsr[15:8]);
      rd8(a, d);
      chk8("storage byte", lfsr[15:8], d);
    end
    wr8(7'h0D, lfsr[7:0]);
    rd8(7'h0D, d);
    chk8("fixed byte", 8'h80, d);
    $display("test map done");
    // Every rate code on the wave, then disabled
    wr8(7'h0B, 8'h08);
    for (int c = 0; c < 16; c++) begin
      wr8(7'h0A, {4'h2, 4'(c)});
      count_wave(512, r);
      chkn("square rises", exp_rises(c, 512), r, 1);
    end
    wr8(7'h0B, 8'h00);
    count_wave(64, r);
    chkn("square idle", 0, r, 0);
    // Raw crystal out, periodic request kept
    wr8(7'h0A, 8'h33);
    wr8(7'h0C, 8'h01);
    wr8(7'h0B, 8'h48);
    count_wave(64, r);
    chkn("raw rises", 32, r, 1);
    wait_irq(100);
    rd8(7'h0C, d);
    chk8("flags periodic", 8'hC1, d);
    wr8(7'h0C, 8'h00);
    wr8(7'h0B, 8'h00);
    rd8(7'h0C, d);
    repeat (40) @(posedge clk);
    chk8("request masked", 8'h01, {7'h00, irq_oe_n});
    rd8(7'h0C, d);
    chk8("flags masked", 8'h40, d);
    $display("test rates done");
    // Frozen setting, then one update with alarm
    wr8(7'h0A, 8'h00);
    wr8(7'h0C, 8'h01);
    rd8(7'h0C, d);
    chk8("fast enable locked", 8'h00, {7'h00, d[0]});
    wr8(7'h0B, 8'h86);
    for (int i = 0; i < 10; i++) wr8(7'(i), tset[i]);
    wr8(7'h0B, 8'h36);
    wr8(7'h0A, 8'h20);
    poll(7'h0A, 7, d);
    chk8("pending set", 8'hA0, d);
    wait_irq(200);
    rd8(7'h0C, d);
    chk8("flags update", 8'hB0, d);
    rd8(7'h0A, d);
    chk8("pending clear", 8'h20, d);
    for (int i = 0; i < 10; i++) begin
      rd8(7'(i), d);
      chk8("rolled byte", troll[i], d);
    end
    $display("test update done");
    // Held copy across an update, decimal 12-hour coding
    wr8(7'h0A, 8'h00);
    wr8(7'h0B, 8'h90);
    wr8(7'h00, 8'h59);
    wr8(7'h02, 8'h59);
    wr8(7'h04, 8'h11);
    wr8(7'h0A, 8'h20);
    poll(7'h0C, 4, d);
    chk8("flags frozen", 8'h30, d);
    chk8("request frozen", 8'h01, {7'h00, irq_oe_n});
    rd8(7'h00, d);
    chk8("frozen seconds", 8'h59, d);
    wr8(7'h0B, 8'h10);
    for (int i = 0; i < 3; i++) begin
      rd8(7'(2 * i), d);
      chk8("released byte", (i == 2) ? 8'h92 : 8'h00, d);
    end
    $display("test freeze done");
    wrap_up();
  end
endmodule // rtc_update_alarm_interrupts_tb_top
`default_nettype wire
